// *** bench/mrfs_host_model.sv ***
// host microcontroller as spi master, mode 0, msb first
module mrfs_host_model (
  // clock
  input wire logic clk,
  // spi pins
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  // each sck level lasts this many clocks, the slave needs at least 4
  localparam int HALF = 5;
  logic bit_q;
  logic idle_q;

  // sck stands still low between frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    bit_q = 1'b0;
    idle_q = 1'b0;
  end

  // mosi carries nothing outside a frame, so keep it moving
  always @(posedge clk) begin
    idle_q <= ~idle_q;
  end
  assign mosi = cs_n ? idle_q : bit_q;

  // select the slave and give it time to see cs fall
  task automatic frame_begin();
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (HALF) @(posedge clk);
  endtask

  task automatic frame_end();
    @(posedge clk);
    cs_n <= 1'b1;
    repeat (HALF) @(posedge clk);
  endtask

  // one byte each way, miso taken just before the rising sck
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      bit_q <= tx[i];
      repeat (HALF) @(posedge clk);
      rx[i] = miso;
      sck <= 1'b1;
      repeat (HALF) @(posedge clk);
      sck <= 1'b0;
    end
  endtask

  // a whole command byte in its own select period
  task automatic command(input logic [7:0] code);
    logic [7:0] unused;
    frame_begin();
    xfer(code, unused);
    frame_end();
  endtask
endmodule

// *** bench/tb_top.sv ***
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (g), (e)); end end

module tb_top
  import mrfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 90000;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, line_cycle, idle_q;
  logic sck, mosi, cs_n, miso_o, miso_oe, miso_w, ready_n, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] words [211];
  logic [7:0] got [484];
  logic [7:0] exp_q [$];
  int error_cnt, samples_checked, wi, cycles;
  integer seed = 32'h7B8DB60D;

  mrfs_top dut (.SYS_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SPI_SCK(sck), .SPI_MOSI(mosi), .SPI_CS_N(cs_n), .SPI_MISO_O(miso_o),
    .SPI_MISO_OE(miso_oe), .LINE_CYCLE(line_cycle), .RESULT_READY_LINE_N(ready_n));
  mrfs_host_model host (.clk(clk), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso_w));

  // released miso keeps changing so a stale bit never matches by luck
  always @(posedge clk) idle_q <= ~idle_q;
  assign miso_w = miso_oe ? miso_o : idle_q;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // a hang ends the run as a failure
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      error_cnt++;
      end_sim();
    end
  end

  // apb master: request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // line cycle pulses with random spacing
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (1 + ($random(seed) & 3)) @(posedge clk);
      line_cycle <= 1'b1;
      @(posedge clk);
      line_cycle <= 1'b0;
    end
  endtask

  // stalls on a full fifo until the frame drains it
  task automatic feed();
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 211; i++) apb(1'b1, OFF_DATA, words[i], r, e);
  endtask

  // expected bytes of n fields of nb bytes: low word first, high byte first
  task automatic add(input int n, input int nb);
    logic [31:0] v;
    repeat (n) begin
      v = words[wi];
      wi++;
      if (nb == 4) exp_q = {exp_q, v[15:8], v[7:0], v[31:24], v[23:16]};
      else if (nb == 2) exp_q = {exp_q, v[15:8], v[7:0]};
      else exp_q.push_back(v[7:0]);
    end
  endtask

  initial begin
    {rstn, psel, penable, pwrite, line_cycle, idle_q} = '0;
    paddr = '0;
    pwdata = '0;
    cycles = 0;
    for (int i = 0; i < 211; i++) words[i] = $random(seed);
    words[0] = 32'h00005A10;
    words[1] = 32'h0000278B;
    words[2] = 32'h000D1C4A;
    // frame layout worked out field by field
    exp_q = {REQ_CODE};
    wi = 0;
    for (int p = 0; p < 3; p++) begin
      add(2, 2);
      add(4, 4);
      add(1, 2);
      add(5, 4);
    end
    add(4, 4);
    add(1, 2);
    add(5, 4);
    add(1, 2);
    add(12, 1);
    add(18, 2);
    exp_q.push_back(CAL_DONE_CODE);
    add(2, 1);
    add(132, 2);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    `CHK(ready_n, 1'b1)
    `CHK(9'(exp_q.size()), FRAME_BYTES)
    apb(1'b0, OFF_CTRL, 32'h0, rd, er);
    `CHK(rd, 32'h00000001)
    apb(1'b0, 8'h10, 32'h0, rd, er);
    `CHK({er, rd}, 33'h100000000)
    // pulses before the request must not count
    pulses(5);
    fork
      feed();
    join_none
    host.command(REQ_CODE);
    pulses(31);
    repeat (3) @(posedge clk);
    `CHK(ready_n, 1'b1)
    pulses(1);
    @(posedge clk);
    #1;
    `CHK(ready_n, 1'b0)
    // full frame plus two bytes past its end, well under the host cap
    host.frame_begin();
    for (int i = 0; i < 484; i++) host.xfer(8'hFF, got[i]);
    host.frame_end();
    wait fork;
    for (int i = 0; i < 482; i++) `CHK(got[i], exp_q[i])
    `CHK(got[127], exp_q[127])
    `CHK(got[0], REQ_CODE)
    `CHK(got[215], CAL_DONE_CODE)
    `CHK({got[1], got[2]}, 16'h5A10)
    `CHK({got[3], got[4]}, 16'h278B)
    `CHK({got[5], got[6], got[7], got[8]}, 32'h1C4A000D)
    `CHK({got[482], got[483]}, {PAD_BYTE, PAD_BYTE})
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    `CHK(rd[3:2], 2'b10)
    // new request with an empty fifo: line rises at once, fields underrun
    host.command(REQ_CODE);
    `CHK(ready_n, 1'b1)
    pulses(32);
    @(posedge clk);
    host.frame_begin();
    for (int i = 0; i < 3; i++) host.xfer(8'hFF, got[i]);
    host.frame_end();
    `CHK(got[0], REQ_CODE)
    `CHK({got[1], got[2]}, {UNDERRUN_BYTE, 8'h00})
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    `CHK(rd[2], 1'b1)
    apb(1'b1, OFF_STATUS, 32'h00000004, rd, er);
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    `CHK(rd[2], 1'b0)
    // disabled: a request is ignored, the line stays low
    apb(1'b1, OFF_CTRL, 32'h0, rd, er);
    host.command(REQ_CODE);
    `CHK(ready_n, 1'b0)
    apb(1'b0, OFF_LAST_CMD, 32'h0, rd, er);
    `CHK(rd[7:0], REQ_CODE)
    // one queued field, then a flush empties the fifo at once
    apb(1'b1, OFF_DATA, 32'h0000_1234, rd, er);
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    `CHK(rd[12:8], 5'h01)
    apb(1'b1, OFF_CTRL, 32'h0000_0002, rd, er);
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    `CHK(rd[12:8], 5'h00)
    end_sim();
  end
endmodule

// *** rtl/mrfs_fifo.sv ***
module mrfs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign count = cnt_q;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointers wrap at depth, flush empties at once
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (flush) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end else begin
      if (push) wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      if (push && !pop) cnt_d = cnt_q + 1'b1;
      else if (pop && !push) cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset, only the pointers matter
  always_ff @(posedge clk) begin
    if (push && !flush) mem_q[wr_q] <= in_data;
  end

  no_overflow_a: assert property (@(posedge clk) disable iff (!rstn)
    !flush && !out_ready && cnt_q == CW'(DEPTH) |=> cnt_q == CW'(DEPTH))
    else $error("fifo count lost while full");
endmodule

// *** rtl/mrfs_pkg.sv ***
package mrfs_pkg;
  // frame constants
  localparam logic [7:0] REQ_CODE = 8'h45;
  localparam logic [7:0] CAL_DONE_CODE = 8'hEF;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic [7:0] UNDERRUN_BYTE = 8'hFF;
  localparam logic [5:0] LINE_CYCLES = 6'h20;
  localparam logic [8:0] FRAME_BYTES = 9'h1E2;
  localparam logic [8:0] IDX_TOTALS = 9'h07F;
  localparam logic [8:0] IDX_CAL = 9'h0B3;
  localparam logic [8:0] IDX_MARK = 9'h0D7;
  localparam logic [7:0] HARM_ITEMS = 8'h84;
  localparam int FIFO_DEPTH = 16;
  localparam int WORD_W = 32;
  // apb register offsets and reset values
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_LAST_CMD = 8'h0C;
  localparam logic CTRL_EN_RST = 1'b1;
  // frame segments, walked in this order
  localparam logic [3:0] SEG_HDR = 4'h0, SEG_VI = 4'h1, SEG_PWR = 4'h2, SEG_PF = 4'h3;
  localparam logic [3:0] SEG_EN = 4'h4, SEG_TPWR = 4'h5, SEG_TPF = 4'h6, SEG_TEN = 4'h7;
  localparam logic [3:0] SEG_FREQ = 4'h8, SEG_FLAG = 4'h9, SEG_CAL = 4'hA, SEG_MARK = 4'hB;
  localparam logic [3:0] SEG_TFLAG = 4'hC, SEG_HARM = 4'hD, SEG_DONE = 4'hE;
  typedef enum logic [2:0] {F_IDLE = 3'b001, F_WAIT = 3'b010, F_SEND = 3'b100} mrfs_frm_t;

  // items in a segment
  function automatic logic [7:0] mrfs_items(input logic [3:0] s);
    case (s)
      SEG_VI, SEG_TFLAG: return 8'h02;
      SEG_PWR, SEG_TPWR: return 8'h04;
      SEG_EN, SEG_TEN: return 8'h05;
      SEG_FLAG: return 8'h0C;
      SEG_CAL: return 8'h12;
      SEG_HARM: return HARM_ITEMS;
      default: return 8'h01;
    endcase
  endfunction

  // bytes per item of a segment
  function automatic logic [2:0] mrfs_width(input logic [3:0] s);
    case (s)
      SEG_PWR, SEG_EN, SEG_TPWR, SEG_TEN: return 3'h4;
      SEG_HDR, SEG_FLAG, SEG_MARK, SEG_TFLAG: return 3'h1;
      default: return 3'h2;
    endcase
  endfunction

  // byte of a value by position: low word first, high byte first in a word
  function automatic logic [7:0] mrfs_pick(input logic [31:0] w, input logic [2:0] nb,
                                           input logic [1:0] pos);
    if (nb == 3'h4) begin
      case (pos)
        2'h0: return w[15:8];
        2'h1: return w[7:0];
        2'h2: return w[31:24];
        default: return w[23:16];
      endcase
    end else if (nb == 3'h2) begin
      return (pos == 2'h0) ? w[15:8] : w[7:0];
    end
    return w[7:0];
  endfunction
endpackage

// *** rtl/mrfs_spi_if.sv ***
// byte link between the spi slave and the framer
interface mrfs_spi_if;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [7:0] tx_byte;
  modport slave (output rx_byte, output rx_valid, input tx_byte);
  modport framer (input rx_byte, input rx_valid, output tx_byte);
endinterface

// *** rtl/mrfs_spi_slave.sv ***
module mrfs_spi_slave (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // spi pins, mode 0
  input wire logic sck,
  input wire logic mosi,
  input wire logic cs_n,
  output logic miso_q,
  output logic miso_oe_q,
  // byte side
  mrfs_spi_if.slave link
);
  logic sck_m_q, sck_s_q, sck_p_q, mosi_m_q, mosi_s_q, cs_m_q, cs_s_q, cs_p_q;
  logic [7:0] tx_q, tx_d, rx_q, rx_d, rxb_q, rxb_d;
  logic [2:0] bit_q, bit_d;
  logic miso_d, rxv_q, rxv_d;
  logic rise, fall, cs_fall;

  // edges only from second and third stage flops
  assign rise = sck_s_q & ~sck_p_q;
  assign fall = ~sck_s_q & sck_p_q;
  assign cs_fall = ~cs_s_q & cs_p_q;
  assign link.rx_byte = rxb_q;
  assign link.rx_valid = rxv_q;

  // sample on rise, shift out on fall; next byte loads after the eighth rise
  always_comb begin
    tx_d = tx_q;
    rx_d = rx_q;
    rxb_d = rxb_q;
    bit_d = bit_q;
    miso_d = miso_q;
    rxv_d = 1'b0;
    if (cs_s_q) begin
      bit_d = '0;
    end else if (cs_fall) begin
      tx_d = link.tx_byte;
      miso_d = link.tx_byte[7];
      bit_d = '0;
    end else if (rise) begin
      rx_d = {rx_q[6:0], mosi_s_q};
      bit_d = bit_q + 1'b1;
      if (bit_q == 3'h7) begin
        rxb_d = {rx_q[6:0], mosi_s_q};
        rxv_d = 1'b1;
      end
    end else if (fall) begin
      if (bit_q == 3'h0) begin
        tx_d = link.tx_byte;
        miso_d = link.tx_byte[7];
      end else begin
        tx_d = {tx_q[6:0], 1'b0};
        miso_d = tx_q[6];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {sck_m_q, sck_s_q, sck_p_q, mosi_m_q, mosi_s_q} <= 5'h00;
      {cs_m_q, cs_s_q, cs_p_q} <= 3'h7;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      rxb_q <= 8'h00;
      bit_q <= 3'h0;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
      rxv_q <= 1'b0;
    end else begin
      {sck_m_q, sck_s_q, sck_p_q} <= {sck, sck_m_q, sck_s_q};
      {mosi_m_q, mosi_s_q} <= {mosi, mosi_m_q};
      {cs_m_q, cs_s_q, cs_p_q} <= {cs_n, cs_m_q, cs_s_q};
      tx_q <= tx_d;
      rx_q <= rx_d;
      rxb_q <= rxb_d;
      bit_q <= bit_d;
      miso_q <= miso_d;
      miso_oe_q <= ~cs_s_q;
      rxv_q <= rxv_d;
    end
  end

  byte_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    rxv_q |=> !rxv_q)
    else $error("received byte strobe longer than one cycle");
endmodule

// *** rtl/mrfs_top.sv ***
// The placing of the registers and the APB slave port were decided locally.
module mrfs_top
  import mrfs_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // spi pins, host is master
  input wire logic SPI_SCK,
  input wire logic SPI_MOSI,
  input wire logic SPI_CS_N,
  output logic SPI_MISO_O,
  output logic SPI_MISO_OE,
  // metering core
  input wire logic LINE_CYCLE,
  output logic RESULT_READY_LINE_N
);
  mrfs_spi_if link ();
  mrfs_frm_t frm_q, frm_d;
  logic [5:0] cyc_q, cyc_d;
  logic [3:0] seg_q, seg_d, nseg;
  logic [7:0] item_q, item_d, tx_q, tx_d, last_q, last_d;
  logic [1:0] pos_q, pos_d, phase_q, phase_d;
  logic [31:0] word_q, word_d, prdata_d;
  logic [8:0] idx_q, idx_d;
  logic under_q, under_d, done_q, done_d, ready_n_q, ready_n_d, en_q, en_d;
  logic pready_d, pslverr_d, pready_q;
  logic [2:0] nb;
  logic f_in_ready, f_out_valid, f_pop, push, flush, under_clr;
  logic [31:0] f_out_data;
  logic [4:0] f_count;
  logic sel_ctrl, sel_stat, sel_data, sel_last, known, access, stall, fire;

  mrfs_spi_slave u_spi (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .sck(SPI_SCK),
    .mosi(SPI_MOSI),
    .cs_n(SPI_CS_N),
    .miso_q(SPI_MISO_O),
    .miso_oe_q(SPI_MISO_OE),
    .link(link.slave)
  );

  // software pushes field values in frame order; full fifo stalls the apb write
  mrfs_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .flush(flush),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data(PWDATA),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out_data),
    .count(f_count)
  );

  assign link.tx_byte = tx_q;
  assign nb = mrfs_width(seg_q);

  // apb decode; one wait state, more while the fifo is full
  assign sel_ctrl = (PADDR == OFF_CTRL);
  assign sel_stat = (PADDR == OFF_STATUS);
  assign sel_data = (PADDR == OFF_DATA);
  assign sel_last = (PADDR == OFF_LAST_CMD);
  assign known = sel_ctrl | sel_stat | sel_data | sel_last;
  assign access = PSEL & PENABLE & ~pready_q;
  assign stall = PWRITE & sel_data & ~f_in_ready;
  assign fire = PSEL & PENABLE & pready_q;
  assign push = fire & PWRITE & sel_data;
  assign flush = fire & PWRITE & sel_ctrl & PWDATA[1];
  assign under_clr = fire & PWRITE & sel_stat & PWDATA[2];

  // apb answer and control register
  always_comb begin
    pready_d = access & ~stall;
    pslverr_d = access & ~stall & ~known;
    prdata_d = 32'h0000_0000;
    en_d = en_q;
    if (access && !stall && !PWRITE) begin
      if (sel_ctrl) prdata_d = {31'h0000_0000, en_q};
      if (sel_stat) prdata_d = {7'h00, idx_q, 3'h0, f_count, 4'h0, done_q, under_q,
                                frm_q == F_WAIT, ~ready_n_q};
      if (sel_last) prdata_d = {24'h00_0000, last_q};
    end
    if (fire && PWRITE && sel_ctrl) en_d = PWDATA[0];
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      en_q <= CTRL_EN_RST;
    end else begin
      PRDATA <= prdata_d;
      PREADY <= pready_d;
      PSLVERR <= pslverr_d;
      en_q <= en_d;
    end
  end

  // registered ready read back, so each access answers once
  assign pready_q = PREADY;

  // framer: wait for the request, then walk the segments one byte per spi byte
  always_comb begin
    frm_d = frm_q;
    cyc_d = cyc_q;
    seg_d = seg_q;
    item_d = item_q;
    pos_d = pos_q;
    phase_d = phase_q;
    word_d = word_q;
    tx_d = tx_q;
    idx_d = idx_q;
    done_d = done_q;
    ready_n_d = ready_n_q;
    last_d = link.rx_valid ? link.rx_byte : last_q;
    under_d = under_q & ~under_clr;
    nseg = seg_q;
    f_pop = 1'b0;
    // a dummy such as FFh is no command and just clocks the frame
    if (link.rx_valid && link.rx_byte == REQ_CODE && en_q) begin
      frm_d = F_WAIT;
      cyc_d = 6'h00;
      ready_n_d = 1'b1;
      done_d = 1'b0;
    end else begin
      unique case (frm_q)
        F_IDLE: begin
        end
        F_WAIT: begin
          if (LINE_CYCLE) begin
            if (cyc_q == LINE_CYCLES - 6'h01) begin
              frm_d = F_SEND;
              ready_n_d = 1'b0;
              seg_d = SEG_HDR;
              item_d = 8'h00;
              pos_d = 2'h0;
              phase_d = 2'h0;
              idx_d = 9'h000;
              tx_d = REQ_CODE;
            end else begin
              cyc_d = cyc_q + 6'h01;
            end
          end
        end
        F_SEND: begin
          // the host may stop early; the framer holds its place and the next select goes on from there
          if (link.rx_valid && seg_q != SEG_DONE) begin
            idx_d = idx_q + 9'h001;
            if ({1'b0, pos_q} + 3'h1 < nb) begin
              pos_d = pos_q + 2'h1;
              tx_d = mrfs_pick(word_q, nb, pos_q + 2'h1);
            end else begin
              pos_d = 2'h0;
              if ({1'b0, item_q} + 9'h001 < {1'b0, mrfs_items(seg_q)}) begin
                item_d = item_q + 8'h01;
              end else begin
                item_d = 8'h00;
                if (seg_q == SEG_EN && phase_q != 2'h2) begin
                  nseg = SEG_VI;
                  phase_d = phase_q + 2'h1;
                end else begin
                  nseg = seg_q + 4'h1;
                end
              end
              seg_d = nseg;
              if (nseg == SEG_MARK) begin
                tx_d = CAL_DONE_CODE;
              end else if (nseg == SEG_DONE) begin
                tx_d = PAD_BYTE;
                done_d = 1'b1;
              end else if (f_out_valid) begin
                // counts pass unscaled, the host applies units
                f_pop = 1'b1;
                word_d = f_out_data;
                tx_d = mrfs_pick(f_out_data, mrfs_width(nseg), 2'h0);
              end else begin
                // starved: keep field alignment, mark the byte and flag it
                word_d = 32'h0000_0000;
                tx_d = UNDERRUN_BYTE;
                under_d = 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      frm_q <= F_IDLE;
      cyc_q <= 6'h00;
      seg_q <= SEG_DONE;
      item_q <= 8'h00;
      pos_q <= 2'h0;
      phase_q <= 2'h0;
      word_q <= 32'h0000_0000;
      tx_q <= PAD_BYTE;
      idx_q <= 9'h000;
      done_q <= 1'b0;
      under_q <= 1'b0;
      last_q <= 8'h00;
      RESULT_READY_LINE_N <= 1'b1;
    end else begin
      frm_q <= frm_d;
      cyc_q <= cyc_d;
      seg_q <= seg_d;
      item_q <= item_d;
      pos_q <= pos_d;
      phase_q <= phase_d;
      word_q <= word_d;
      tx_q <= tx_d;
      idx_q <= idx_d;
      done_q <= done_d;
      under_q <= under_d;
      last_q <= last_d;
      RESULT_READY_LINE_N <= ready_n_d;
    end
  end
  assign ready_n_q = RESULT_READY_LINE_N;

  hdr_first_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $fell(RESULT_READY_LINE_N) |-> tx_q == REQ_CODE && seg_q == SEG_HDR && idx_q == 9'h000)
    else $error("frame did not open with the request echo");
  ready_wait_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $fell(RESULT_READY_LINE_N) |-> $past(frm_q) == F_WAIT
      && $past(cyc_q) == LINE_CYCLES - 6'h01 && $past(LINE_CYCLE))
    else $error("ready line fell before 32 line cycles");
  phase_loop_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $rose(seg_q == SEG_VI) && phase_q != 2'h0 |-> $past(seg_q) == SEG_EN
      && phase_q == $past(phase_q) + 2'h1)
    else $error("phase block order broken");
  energy_after_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $rose(seg_q == SEG_EN) |-> $past(seg_q) == SEG_PF && pos_q == 2'h0)
    else $error("energies did not follow power factor");
  totals_at_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $rose(seg_q == SEG_TPWR) |-> idx_q == IDX_TOTALS && phase_q == 2'h2)
    else $error("totals started at the wrong byte");
  flag_bytes_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    seg_q == SEG_FLAG && $changed(idx_q) && !under_q |-> tx_q == word_q[7:0])
    else $error("flag byte not taken from low byte");
  flags_len_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $rose(seg_q == SEG_CAL) |-> idx_q == IDX_CAL)
    else $error("flag group length wrong");
  cal_len_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $rose(seg_q == SEG_MARK) |-> idx_q == IDX_MARK)
    else $error("calibration echo length wrong");
  mark_byte_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $rose(seg_q == SEG_MARK) |-> tx_q == CAL_DONE_CODE ##0 (seg_q == SEG_MARK)[*1])
    else $error("calibration done marker not sent");
  harm_items_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    seg_q == SEG_HARM |-> item_q < HARM_ITEMS)
    else $error("harmonic item count overrun");
  frame_len_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $rose(seg_q == SEG_DONE) |-> idx_q == FRAME_BYTES && done_q)
    else $error("frame length wrong");
  word_swap_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    frm_q == F_SEND && nb == 3'h4 && pos_q == 2'h2 && $changed(pos_q)
      |-> tx_q == word_q[31:24])
    else $error("high word not sent second");
endmodule
